//--- hw/butr_pkg.sv
// Purpose: Constants for the basic update timer register block
// Assumes: APB slave, 32-bit data, byte addresses
// Notes:   Control, mask and reload registers sit at chosen offsets
package butr_pkg;
  localparam logic [11:0] BUTR_CTRL_OFF   = 12'h000;
  localparam logic [11:0] BUTR_MASK_OFF   = 12'h00C;
  localparam logic [11:0] BUTR_STATUS_OFF = 12'h010;
  localparam logic [11:0] BUTR_EVGEN_OFF  = 12'h014;
  localparam logic [11:0] BUTR_COUNT_OFF  = 12'h024;
  localparam logic [11:0] BUTR_PSC_OFF    = 12'h028;
  localparam logic [11:0] BUTR_RELOAD_OFF = 12'h02C;
  // Field positions
  localparam int BUTR_UPF_BIT    = 0;
  localparam int BUTR_FUB_BIT    = 0;
  localparam int BUTR_MIRROR_BIT = 31;
  localparam int BUTR_EN_BIT     = 0;
  localparam int BUTR_UPDATE_DISABLE_BIT   = 1;
  localparam int BUTR_URS_BIT    = 2;
  // Reset values
  localparam logic [15:0] BUTR_COUNT_RST  = 16'h0000;
  localparam logic [15:0] BUTR_PSC_RST    = 16'h0000;
  localparam logic [15:0] BUTR_RELOAD_RST = 16'hFFFF;
  localparam logic [2:0]  BUTR_CTRL_RST   = 3'h0;
endpackage : butr_pkg

//--- hw/butr_timer.sv
// Purpose: Basic 16-bit up-counting timer with update flag, APB slave
// Assumes: Single clock pclk, asynchronous active-low reset
// Notes:   Answers every access with zero wait states, no error
module butr_timer
  import butr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);

  // Whole state of the block
  typedef struct packed {
    logic [31:0] rdata;
    logic        rdy;
    logic        err;
    logic        irq;
    logic [2:0]  ctrl;
    logic        mask;
    logic        upf;
    logic [15:0] cnt;
    logic [15:0] psc_cnt;
    logic [15:0] psc;
    logic [15:0] psc_sh;
    logic [15:0] arr;
    logic [15:0] arr_sh;
  } butr_state_s;

  butr_state_s st_r;
  butr_state_s st_nxt;

  logic acc;
  logic wr;
  logic ug;
  logic ovf;
  logic upd;
  logic flag_set;

  assign acc = psel & penable & st_r.rdy;
  assign wr  = acc & pwrite;
  // Force bit acts only in the write cycle, never stored
  assign ug  = wr && paddr == BUTR_EVGEN_OFF && pwdata[BUTR_FUB_BIT];
  // Counter wraps at reload value when a prescaler tick falls
  assign ovf = st_r.ctrl[BUTR_EN_BIT] && st_r.psc_cnt == st_r.psc_sh
               && st_r.cnt == st_r.arr_sh;
  assign upd = ovf | ug;
  // Overflow gated by disable, forced update by disable and source select
  assign flag_set = (ovf && !st_r.ctrl[BUTR_UPDATE_DISABLE_BIT])
                 || (ug && !st_r.ctrl[BUTR_UPDATE_DISABLE_BIT]
                        && !st_r.ctrl[BUTR_URS_BIT]);

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdy = psel & ~penable;
    // No access is ever refused
    st_nxt.err = 1'b0;
    // Prescaler and counter
    if (st_r.ctrl[BUTR_EN_BIT]) begin
      if (st_r.psc_cnt == st_r.psc_sh) begin
        st_nxt.psc_cnt = 16'h0000;
        st_nxt.cnt = ovf ? 16'h0000 : st_r.cnt + 16'h0001;
      end else begin
        st_nxt.psc_cnt = st_r.psc_cnt + 16'h0001;
      end
    end
    if (upd && !st_r.ctrl[BUTR_UPDATE_DISABLE_BIT]) begin
      st_nxt.psc_sh = st_r.psc;
      st_nxt.arr_sh = st_r.arr;
    end
    // Register writes
    if (wr) begin
      if (paddr == BUTR_CTRL_OFF) begin
        st_nxt.ctrl = pwdata[2:0];
      end else if (paddr == BUTR_MASK_OFF) begin
        st_nxt.mask = pwdata[0];
      end else if (paddr == BUTR_STATUS_OFF) begin
        if (!pwdata[BUTR_UPF_BIT]) begin
          st_nxt.upf = 1'b0;
        end
      end else if (paddr == BUTR_COUNT_OFF) begin
        st_nxt.cnt = pwdata[15:0];
      end else if (paddr == BUTR_PSC_OFF) begin
        st_nxt.psc = pwdata[15:0];
      end else if (paddr == BUTR_RELOAD_OFF) begin
        st_nxt.arr = pwdata[15:0];
      end
    end
    // Forced update restarts counter and prescaler; ratio kept
    if (ug) begin
      st_nxt.cnt = 16'h0000;
      st_nxt.psc_cnt = 16'h0000;
      st_nxt.psc_sh = st_r.psc;
    end
    // Set wins over clear
    if (flag_set) begin
      st_nxt.upf = 1'b1;
    end
    // Read data
    st_nxt.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (paddr == BUTR_CTRL_OFF) begin
        st_nxt.rdata = {29'h0, st_r.ctrl};
      end else if (paddr == BUTR_MASK_OFF) begin
        st_nxt.rdata = {31'h0, st_r.mask};
      end else if (paddr == BUTR_STATUS_OFF) begin
        st_nxt.rdata = {31'h0, st_r.upf};
      end else if (paddr == BUTR_EVGEN_OFF) begin
        st_nxt.rdata = 32'h0000_0000;
      end else if (paddr == BUTR_COUNT_OFF) begin
        st_nxt.rdata = {st_r.upf, 15'h0, st_r.cnt};
      end else if (paddr == BUTR_PSC_OFF) begin
        st_nxt.rdata = {16'h0, st_r.psc};
      end else if (paddr == BUTR_RELOAD_OFF) begin
        st_nxt.rdata = {16'h0, st_r.arr};
      end
    end
    st_nxt.irq = st_nxt.upf & st_nxt.mask;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{rdata: 32'h0, rdy: 1'b0, irq: 1'b0, ctrl: BUTR_CTRL_RST,
                mask: 1'b0, err: 1'b0, upf: 1'b0, cnt: BUTR_COUNT_RST,
                psc_cnt: 16'h0, psc: BUTR_PSC_RST, psc_sh: BUTR_PSC_RST,
                arr: BUTR_RELOAD_RST, arr_sh: BUTR_RELOAD_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata  = st_r.rdata;
  assign pready  = st_r.rdy;
  assign pslverr = st_r.err;
  assign irq     = st_r.irq;

  // Checks
  property p_flag_on_overflow;
    @(posedge pclk) disable iff (!presetn)
      ovf && !st_r.ctrl[BUTR_UPDATE_DISABLE_BIT] |=> st_r.upf;
  endproperty
  a_flag_on_overflow: assert property (p_flag_on_overflow)
    else $error("flag not set on overflow");

  property p_ug_flag;
    @(posedge pclk) disable iff (!presetn)
      ug && st_r.ctrl[2:1] == 2'b00 |=> st_r.upf;
  endproperty
  a_ug_flag: assert property (p_ug_flag)
    else $error("flag not set on forced update");

  property p_no_spurious;
    @(posedge pclk) disable iff (!presetn)
      !st_r.upf ##1 st_r.upf |-> $past(flag_set);
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("flag set without update");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      wr && paddr == BUTR_STATUS_OFF && !pwdata[0] && !flag_set
      |=> !st_r.upf;
  endproperty
  a_clear: assert property (p_clear)
    else $error("flag not cleared by zero write");

  property p_keep;
    @(posedge pclk) disable iff (!presetn)
      st_r.upf && !(wr && paddr == BUTR_STATUS_OFF && !pwdata[0])
      |=> st_r.upf;
  endproperty
  a_keep: assert property (p_keep)
    else $error("flag dropped");

  property p_ug_restart;
    @(posedge pclk) disable iff (!presetn)
      ug |=> st_r.cnt == 16'h0000 && st_r.psc_cnt == 16'h0000;
  endproperty
  a_ug_restart: assert property (p_ug_restart)
    else $error("counter not restarted");

  property p_ratio_kept;
    @(posedge pclk) disable iff (!presetn)
      ug && !(wr && paddr == BUTR_PSC_OFF) ##1 1 |-> $stable(st_r.psc);
  endproperty
  a_ratio_kept: assert property (p_ratio_kept)
    else $error("prescaler ratio changed");

  property p_cnt_write;
    @(posedge pclk) disable iff (!presetn)
      wr && paddr == BUTR_COUNT_OFF |=> st_r.cnt == $past(pwdata[15:0]);
  endproperty
  a_cnt_write: assert property (p_cnt_write)
    else $error("count write lost");

  property p_mirror;
    @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == BUTR_COUNT_OFF
      |=> prdata[31] == $past(st_r.upf);
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("mirror bit wrong");

  property p_evgen_reads_zero;
    @(posedge pclk) disable iff (!presetn)
      psel && !penable && paddr == BUTR_EVGEN_OFF |=> prdata == 32'h0;
  endproperty
  a_evgen_reads_zero: assert property (p_evgen_reads_zero)
    else $error("event register not zero");

  property p_status_read;
    @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == BUTR_STATUS_OFF
      |=> prdata == {31'h0, $past(st_r.upf)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read wrong");

  property p_count_read;
    @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == BUTR_COUNT_OFF
      |=> prdata[15:0] == $past(st_r.cnt);
  endproperty
  a_count_read: assert property (p_count_read)
    else $error("count read wrong");

  property p_count_reserved;
    @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == BUTR_COUNT_OFF
      |=> prdata[30:16] == 15'h0000;
  endproperty
  a_count_reserved: assert property (p_count_reserved)
    else $error("count reserved bits not zero");

  property p_evgen_no_action;
    @(posedge pclk) disable iff (!presetn)
      wr && paddr == BUTR_EVGEN_OFF && !pwdata[BUTR_FUB_BIT]
      && !st_r.ctrl[BUTR_EN_BIT] |=> $stable(st_r.cnt);
  endproperty
  a_evgen_no_action: assert property (p_evgen_no_action)
    else $error("zero force write moved counter");

  property p_evgen_zero_quiet;
    @(posedge pclk) disable iff (!presetn)
      wr && paddr == BUTR_EVGEN_OFF && !pwdata[BUTR_FUB_BIT]
      && !ovf && !st_r.upf |=> !st_r.upf;
  endproperty
  a_evgen_zero_quiet: assert property (p_evgen_zero_quiet)
    else $error("zero force write set flag");

  property p_ug_psc_shadow;
    @(posedge pclk) disable iff (!presetn)
      ug
      |=> st_r.psc_sh == $past(st_r.psc);
  endproperty
  a_ug_psc_shadow: assert property (p_ug_psc_shadow)
    else $error("prescaler shadow not loaded");

  property p_ug_reload_shadow;
    @(posedge pclk) disable iff (!presetn)
      ug && !st_r.ctrl[BUTR_UPDATE_DISABLE_BIT]
      |=> st_r.arr_sh == $past(st_r.arr);
  endproperty
  a_ug_reload_shadow: assert property (p_ug_reload_shadow)
    else $error("reload shadow not loaded");

  property p_ug_quiet_source;
    @(posedge pclk) disable iff (!presetn)
      ug && st_r.ctrl[BUTR_URS_BIT] && !ovf && !st_r.upf
      |=> !st_r.upf;
  endproperty
  a_ug_quiet_source: assert property (p_ug_quiet_source)
    else $error("flag set with source select");

  property p_ug_quiet_disable;
    @(posedge pclk) disable iff (!presetn)
      ug && st_r.ctrl[BUTR_UPDATE_DISABLE_BIT] && !st_r.upf
      |=> !st_r.upf;
  endproperty
  a_ug_quiet_disable: assert property (p_ug_quiet_disable)
    else $error("forced flag set while disabled");

  property p_ovf_quiet_disable;
    @(posedge pclk) disable iff (!presetn)
      ovf && st_r.ctrl[BUTR_UPDATE_DISABLE_BIT] && !st_r.upf
      |=> !st_r.upf;
  endproperty
  a_ovf_quiet_disable: assert property (p_ovf_quiet_disable)
    else $error("overflow flag set while disabled");

  property p_ovf_wrap;
    @(posedge pclk) disable iff (!presetn)
      ovf && !ug && !(wr && paddr == BUTR_COUNT_OFF)
      |=> st_r.cnt == 16'h0000;
  endproperty
  a_ovf_wrap: assert property (p_ovf_wrap)
    else $error("counter did not wrap");

  property p_keep_on_one;
    @(posedge pclk) disable iff (!presetn)
      st_r.upf && wr && paddr == BUTR_STATUS_OFF && pwdata[BUTR_UPF_BIT]
      |=> st_r.upf;
  endproperty
  a_keep_on_one: assert property (p_keep_on_one)
    else $error("flag cleared by one write");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      1'b1
      |-> irq == (st_r.upf && st_r.mask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level wrong");

  property p_irq_low;
    @(posedge pclk) disable iff (!presetn)
      !st_r.upf
      |-> !irq;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("interrupt without flag");

  property p_mirror_read_only;
    @(posedge pclk) disable iff (!presetn)
      wr && paddr == BUTR_COUNT_OFF && pwdata[BUTR_MIRROR_BIT]
      && !flag_set && !st_r.upf |=> !st_r.upf;
  endproperty
  a_mirror_read_only: assert property (p_mirror_read_only)
    else $error("mirror write set flag");

endmodule : butr_timer

//--- tb/butr_timer_test.sv
// Purpose: Register-level bench of the basic update timer
// Assumes: APB slave answers with pready, writes land at the access edge
// Notes:   A reload of 3 keeps the overflow wait short
module butr_timer_test
  import butr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [31:0] rdata;
  int          errors   = 0;
  int          n_checks = 0;
  int          cyc      = 0;

  butr_timer butr_timer_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .irq     (irq)
  );

  // Clock and hang guard
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      results();
    end
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, held until pready
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdata, exp);
    chk({31'h0, pslverr}, 32'h0);
  endtask : rd

  // Verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(BUTR_STATUS_OFF, 32'h0);
    rd(BUTR_EVGEN_OFF, 32'h0);
    rd(BUTR_COUNT_OFF, 32'h0);
    rd(12'h100, 32'h0);
    wr(BUTR_COUNT_OFF, 32'hFFFF_5A5A);
    rd(BUTR_COUNT_OFF, 32'h0000_5A5A);
    wr(BUTR_RELOAD_OFF, 32'h3);
    wr(BUTR_EVGEN_OFF, 32'h1);
    rd(BUTR_COUNT_OFF, 32'h8000_0000);
    rd(BUTR_EVGEN_OFF, 32'h0);
    rd(BUTR_STATUS_OFF, 32'h1);
    wr(BUTR_STATUS_OFF, 32'h1);
    rd(BUTR_STATUS_OFF, 32'h1);
    wr(BUTR_MASK_OFF, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(BUTR_STATUS_OFF, 32'h0);
    rd(BUTR_STATUS_OFF, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(BUTR_COUNT_OFF, 32'h55);
    wr(BUTR_EVGEN_OFF, 32'h0);
    rd(BUTR_COUNT_OFF, 32'h55);
    // Forced update with disable or source select set
    for (int c = 2; c <= 6; c += 2) begin
      wr(BUTR_CTRL_OFF, 32'(c));
      wr(BUTR_EVGEN_OFF, 32'h1);
      rd(BUTR_STATUS_OFF, 32'h0);
      rd(BUTR_COUNT_OFF, 32'h0);
    end
    // Forced update keeps the programmed ratio
    wr(BUTR_PSC_OFF, 32'h1);
    wr(BUTR_EVGEN_OFF, 32'h1);
    rd(BUTR_PSC_OFF, 32'h1);
    rd(BUTR_COUNT_OFF, 32'h0);
    // Overflow with and without update disable
    wr(BUTR_CTRL_OFF, 32'h3);
    repeat (20) @(posedge pclk);
    rd(BUTR_STATUS_OFF, 32'h0);
    wr(BUTR_CTRL_OFF, 32'h1);
    repeat (20) @(posedge pclk);
    rd(BUTR_STATUS_OFF, 32'h1);
    results();
  end
endmodule : butr_timer_test
